//--- inc/sts_pkg.sv
// Purpose: shared constants and carriers for the scan trigger sequencer
// Assumes: single 250 MHz clock, all inputs synchronous
// Notes: counter widths follow the documented counter sizes
package sts_pkg;

  localparam int PSC_W = 24;
  localparam int NCH_W = 9;
  localparam int M_W = 16;
  localparam int DLY_W = 16;
  localparam int RTG_W = 16;
  localparam int SIC_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 32;
  localparam int SIZE_W = 22;
  localparam int HIST_DEPTH = 8;
  localparam int HIST_AW = 3;
  localparam logic [SIZE_W-1:0] MAX_XFER = 22'h200000;
  localparam logic [PSC_W-1:0] PSC_RST = 24'h000000;
  localparam logic [1:0] IDX_RST = 2'h0;

  typedef enum logic [1:0]
  {
    MODE_PRE = 2'b00,
    MODE_MID = 2'b01,
    MODE_POST = 2'b10,
    MODE_DELAY = 2'b11
  } sts_mode_type;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_DELAY = 3'b010,
    ST_POST = 3'b011,
    ST_REARM = 3'b100,
    ST_DRAIN = 3'b101
  } sts_state_type;

  // acquisition configuration, held stable while running
  typedef struct packed
  {
    sts_mode_type mode;
    logic guard_en;
    logic retrig_en;
    logic dly_on_sample;
    logic [PSC_W-1:0] post_scan_count;
    logic [NCH_W-1:0] samples_per_scan;
    logic [M_W-1:0] pre_scan_count;
    logic [DLY_W-1:0] delay_count;
    logic [RTG_W-1:0] retrig_limit;
    logic [SIC_W-1:0] sample_interval_count;
  } sts_cfg_type;

  // one converted sample with its scan-start mark
  typedef struct packed
  {
    logic first;
    logic [DATA_W-1:0] data;
  } sts_smp_type;

  // chained transfer descriptor as fetched by software-built list
  typedef struct packed
  {
    logic [ADDR_W-1:0] host_addr;
    logic [ADDR_W-1:0] local_addr;
    logic [SIZE_W-1:0] size;
    logic [ADDR_W-1:0] next_ptr;
    logic last;
  } sts_desc_type;

  // write beat toward host memory
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sts_beat_type;

endpackage : sts_pkg

//--- rtl/sts_skid.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, source holds data while valid and not ready
// Notes: ready to source is registered, so no word is lost on a stall
`timescale 1ns/10ps
module sts_skid
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  input wire sts_pkg::sts_beat_type in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output sts_pkg::sts_beat_type out_data_out,
  input wire logic out_ready_in
);

  typedef struct packed
  {
    sts_pkg::sts_beat_type [1:0] mem;
    logic [1:0] cnt;
    logic rd;
    logic wr;
  } sts_skid_type;

  sts_skid_type s_q;
  sts_skid_type s_d;
  logic push;
  logic pop;

  // two slots: full and empty follow the occupancy count exactly
  always_comb
  begin
    s_d = s_q;
    push = in_valid_in && (s_q.cnt != 2'h2);
    pop = out_ready_in && (s_q.cnt != 2'h0);
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data_in;
      s_d.wr = ~s_q.wr;
    end
    if (pop)
      s_d.rd = ~s_q.rd;
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign in_ready_out = (s_q.cnt != 2'h2);
  assign out_valid_out = (s_q.cnt != 2'h0);
  assign out_data_out = s_q.mem[s_q.rd];

endmodule : sts_skid

//--- rtl/sts_seq.sv
// Purpose: trigger-relative scan storage and chained transfer to host
// Assumes: samples arrive one per beat, first channel marked by first
// Notes: pre-scan history held in flip-flops, depth HIST_DEPTH scans
`timescale 1ns/10ps
module sts_seq
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire sts_pkg::sts_cfg_type cfg_in,
  input wire logic chain_en_in,
  input wire logic trigger_in,
  input wire logic timebase_tick_in,
  input wire logic smp_valid_in,
  input wire sts_pkg::sts_smp_type smp_in,
  input wire sts_pkg::sts_desc_type desc_in,
  input wire logic desc_valid_in,
  output logic desc_req_out,
  output logic [sts_pkg::ADDR_W-1:0] desc_ptr_out,
  input wire logic [sts_pkg::ADDR_W-1:0] first_desc_in,
  output logic wr_valid_out,
  output sts_pkg::sts_beat_type wr_beat_out,
  input wire logic wr_ready_in,
  output logic busy_out,
  output logic done_out,
  output logic trig_seen_out,
  output logic smp_ready_out
);

  typedef struct packed
  {
    sts_pkg::sts_state_type st;
    logic [sts_pkg::PSC_W-1:0] post_left;
    logic [sts_pkg::M_W-1:0] pre_done;
    logic [sts_pkg::DLY_W-1:0] dly;
    logic [sts_pkg::RTG_W-1:0] rtg;
    logic [sts_pkg::SIC_W-1:0] sdiv;
    logic [sts_pkg::NCH_W-1:0] idx;
    logic in_scan;
    logic stop_at_end;
    logic [sts_pkg::HIST_AW-1:0] hist_wr;
    logic [sts_pkg::HIST_AW-1:0] hist_rd;
    logic [sts_pkg::HIST_AW:0] hist_cnt;
    logic [sts_pkg::NCH_W-1:0] drain_idx;
    logic [sts_pkg::ADDR_W-1:0] addr;
    logic [sts_pkg::SIZE_W-1:0] left;
    logic have_desc;
    logic desc_req;
    logic desc_last;
    logic [sts_pkg::ADDR_W-1:0] next_ptr;
    logic busy;
    logic done;
    logic trig_seen;
  } sts_core_type;

  sts_core_type c_q;
  sts_core_type c_d;
  logic [sts_pkg::DATA_W-1:0] hist [0:sts_pkg::HIST_DEPTH-1]
    [0:(1<<sts_pkg::NCH_W)-1];
  logic buf_ready;
  logic buf_valid;
  sts_pkg::sts_beat_type buf_beat;
  logic bv;
  sts_pkg::sts_beat_type bb;
  logic trig_ok;
  logic dly_tick;
  logic scan_end;
  logic hist_push;
  logic beat_go;
  logic [sts_pkg::NCH_W-1:0] cur_idx;

  // advance a modulo index, shared by history pointers
  function automatic logic [sts_pkg::HIST_AW-1:0] hinc
  (
    input logic [sts_pkg::HIST_AW-1:0] p
  );
    hinc = p + 3'h1;
  endfunction : hinc

  // one-step delay down-counter with zero stop
  function automatic logic [sts_pkg::DLY_W-1:0] dec16
  (
    input logic [sts_pkg::DLY_W-1:0] v
  );
    dec16 = (v == '0) ? v : v - 16'h0001;
  endfunction : dec16

  // a beat moves only with buffer room and a loaded descriptor; a reload
  // takes three cycles, samples arriving meanwhile are lost
  assign beat_go = buf_ready && c_q.have_desc;

  // a marked first channel restarts the index, so a scan cut short at
  // start is simply overwritten
  assign cur_idx = (smp_valid_in && smp_in.first) ? '0 : c_q.idx;

  // last channel of a scan ends it, whatever the trigger timing
  assign scan_end = smp_valid_in && beat_go &&
    (cur_idx == cfg_in.samples_per_scan - 9'h001);

  // history write of the latest scans, the cut-off scan included
  assign hist_push = smp_valid_in && (c_q.st == sts_pkg::ST_PRE);

  always_ff @(posedge clock_in)
  begin
    if (hist_push)
      hist[c_q.hist_wr][cur_idx] <= smp_in.data;
  end

  // delay counter clock: raw timebase or the divided sample clock
  assign dly_tick = timebase_tick_in &&
    (!cfg_in.dly_on_sample || c_q.sdiv == '0);

  // guard holds off triggers until the pre scans are converted
  assign trig_ok = trigger_in &&
    (!cfg_in.guard_en || c_q.pre_done >= cfg_in.pre_scan_count);

  always_comb
  begin
    c_d = c_q;
    bv = 1'b0;
    bb = '0;
    c_d.done = 1'b0;
    c_d.desc_req = 1'b0;
    // sample clock divider, free while busy
    if (timebase_tick_in)
      c_d.sdiv = (c_q.sdiv == '0) ?
        cfg_in.sample_interval_count - 16'h0001 : c_q.sdiv - 16'h0001;
    // channel index within a scan
    if (smp_valid_in && beat_go)
      c_d.idx = scan_end ? '0 : cur_idx + 9'h001;
    unique case (c_q.st)
      sts_pkg::ST_IDLE:
      begin
        if (start_in)
        begin
          c_d.busy = 1'b1;
          c_d.trig_seen = 1'b0;
          c_d.pre_done = '0;
          c_d.hist_cnt = '0;
          c_d.idx = '0;
          c_d.stop_at_end = 1'b0;
          c_d.in_scan = 1'b0;
          c_d.rtg = cfg_in.retrig_limit;
          c_d.post_left = cfg_in.post_scan_count;
          c_d.dly = cfg_in.delay_count;
          unique case (cfg_in.mode)
            sts_pkg::MODE_PRE, sts_pkg::MODE_MID: c_d.st = sts_pkg::ST_PRE;
            sts_pkg::MODE_POST: c_d.st = sts_pkg::ST_REARM;
            sts_pkg::MODE_DELAY: c_d.st = sts_pkg::ST_REARM;
          endcase
        end
      end
      sts_pkg::ST_PRE:
      begin
        if (trig_ok && !c_q.stop_at_end)
        begin
          c_d.trig_seen = 1'b1;
          // a scan in progress finishes before the switch
          c_d.stop_at_end = (cur_idx != '0) && !scan_end;
          if (cur_idx == '0 || scan_end)
            c_d.st = sts_pkg::ST_DRAIN;
        end
        if (scan_end)
        begin
          c_d.pre_done = (c_q.pre_done == 16'hffff) ?
            c_q.pre_done : c_q.pre_done + 16'h0001;
          c_d.hist_wr = hinc(c_q.hist_wr);
          // middle mode: the interrupted scan is the first post scan
          if (c_q.stop_at_end && cfg_in.mode == sts_pkg::MODE_MID &&
              c_q.post_left != '0)
          begin
            c_d.post_left = c_q.post_left - 24'h000001;
            if (c_q.hist_cnt == 4'h8)
              c_d.hist_rd = hinc(c_q.hist_rd);
            else
              c_d.hist_cnt = c_q.hist_cnt + 4'h1;
          end
          else if ({12'h000, c_q.hist_cnt} == cfg_in.pre_scan_count ||
              c_q.hist_cnt == 4'h8)
            c_d.hist_rd = hinc(c_q.hist_rd); // keep only latest M, at most 8
          else
            c_d.hist_cnt = c_q.hist_cnt + 4'h1;
          if (c_q.stop_at_end)
            c_d.st = sts_pkg::ST_DRAIN;
        end
      end
      sts_pkg::ST_DRAIN:
      begin
        // stored pre scans out first, whole scans only
        if (c_q.hist_cnt == '0)
        begin
          if (cfg_in.mode == sts_pkg::MODE_MID &&
              c_q.post_left != '0)
            c_d.st = sts_pkg::ST_POST;
          else
          begin
            c_d.st = sts_pkg::ST_IDLE;
            c_d.busy = 1'b0;
            c_d.done = 1'b1;
          end
        end
        else if (beat_go)
        begin
          bv = 1'b1;
          bb.data = hist[c_q.hist_rd][c_q.drain_idx];
          bb.addr = c_q.addr;
          c_d.drain_idx = c_q.drain_idx + 9'h001;
          if (c_q.drain_idx == cfg_in.samples_per_scan - 9'h001)
          begin
            c_d.drain_idx = '0;
            c_d.hist_rd = hinc(c_q.hist_rd);
            c_d.hist_cnt = c_q.hist_cnt - 4'h1;
          end
        end
      end
      sts_pkg::ST_REARM:
      begin
        // triggers before the previous scans complete never got here
        if (trigger_in)
        begin
          c_d.trig_seen = 1'b1;
          c_d.dly = cfg_in.delay_count;
          c_d.post_left = cfg_in.post_scan_count;
          c_d.st = (cfg_in.mode == sts_pkg::MODE_DELAY) ?
            sts_pkg::ST_DELAY : sts_pkg::ST_POST;
        end
      end
      sts_pkg::ST_DELAY:
      begin
        if (c_q.dly == '0)
          c_d.st = sts_pkg::ST_POST;
        else if (dly_tick)
          c_d.dly = dec16(c_q.dly);
      end
      sts_pkg::ST_POST:
      begin
        // store whole scans starting at a first channel
        if (smp_valid_in && (c_q.in_scan || smp_in.first))
        begin
          bv = 1'b1;
          bb.data = smp_in.data;
          bb.addr = c_q.addr;
        end
        if (smp_valid_in && beat_go && (c_q.in_scan || smp_in.first))
        begin
          c_d.in_scan = !scan_end;
          if (scan_end)
            c_d.post_left = c_q.post_left - 24'h000001;
          // only a stored scan can close the burst
          if (scan_end && c_q.post_left == 24'h000001)
          begin
            c_d.in_scan = 1'b0;
            if (cfg_in.retrig_en && c_q.rtg > 16'h0001 &&
                cfg_in.mode != sts_pkg::MODE_MID)
            begin
              c_d.rtg = c_q.rtg - 16'h0001;
              c_d.st = sts_pkg::ST_REARM;
            end
            else
            begin
              c_d.st = sts_pkg::ST_IDLE;
              c_d.busy = 1'b0;
              c_d.done = 1'b1;
            end
          end
        end
      end
      default:
        c_d.st = sts_pkg::ST_IDLE;
    endcase
    // transfer walker: address and remaining size per accepted beat
    if (bv && beat_go)
    begin
      c_d.addr = c_q.addr + 32'h00000004;
      c_d.left = c_q.left - 22'h000001;
      if (c_q.left == 22'h000001)
      begin
        c_d.have_desc = 1'b0;
        // non-chained or last descriptor: restart at the first block, size capped at 2M
        if (!chain_en_in || c_q.desc_last)
        begin
          c_d.left = sts_pkg::MAX_XFER;
          c_d.addr = first_desc_in;
          c_d.have_desc = 1'b1;
        end
        else
          c_d.desc_req = 1'b1;
      end
    end
    // load next descriptor, circular lists simply loop back
    if (desc_valid_in && !c_q.have_desc)
    begin
      c_d.addr = desc_in.host_addr;
      c_d.left = (desc_in.size == '0) ? 22'h000001 : desc_in.size;
      c_d.next_ptr = desc_in.next_ptr;
      c_d.desc_last = desc_in.last;
      c_d.have_desc = 1'b1;
    end
    if (start_in && c_q.st == sts_pkg::ST_IDLE)
    begin
      c_d.have_desc = !chain_en_in;
      c_d.addr = first_desc_in;
      c_d.left = sts_pkg::MAX_XFER;
      c_d.next_ptr = first_desc_in;
      c_d.desc_req = chain_en_in;
      c_d.desc_last = 1'b0;
    end
  end

  // sample beats are dropped while no descriptor is loaded
  assign buf_valid = bv && c_q.have_desc;
  assign smp_ready_out = 1'b1;

  sts_skid u_skid
  (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .in_valid_in(buf_valid),
    .in_data_in(bb),
    .in_ready_out(buf_ready),
    .out_valid_out(wr_valid_out),
    .out_data_out(wr_beat_out),
    .out_ready_in(wr_ready_in)
  );

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  assign desc_req_out = c_q.desc_req;
  assign desc_ptr_out = c_q.next_ptr;
  assign busy_out = c_q.busy;
  assign done_out = c_q.done;
  assign trig_seen_out = c_q.trig_seen;

endmodule : sts_seq

//--- tb/sts_seq_properties.sv
// Purpose: port-level checks on the scan trigger sequencer
// Assumes: one clock domain, async active-low reset
// Notes: watches only the sequencer ports, its outputs except desc_ptr_out and some of its inputs
`timescale 1ns/10ps
module sts_seq_chk
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic chain_en_in,
  input wire logic trigger_in,
  input wire logic desc_req_out,
  input wire logic wr_valid_out,
  input wire sts_pkg::sts_beat_type wr_beat_out,
  input wire logic wr_ready_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic trig_seen_out,
  input wire logic smp_ready_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // launch from idle, trigger state cleared so guard starts fresh
  sequence s_launch;
    start_in && !busy_out;
  endsequence
  sequence s_fresh;
    busy_out && !trig_seen_out && !done_out;
  endsequence
  property p_launch;
    s_launch |=> s_fresh;
  endproperty
  a_launch: assert property (p_launch) else $error("no clean launch");
  property p_done_pulse;
    done_out |=> !done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_busy_end;
    $fell(busy_out) |-> done_out || $past(done_out);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell alone");
  property p_done_idle;
    done_out |-> ##[0:1] !busy_out;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  property p_beat_hold;
    wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_beat_out);
  endproperty
  a_beat_hold: assert property (p_beat_hold) else $error("beat dropped");
  property p_desc_pulse;
    desc_req_out |=> !desc_req_out;
  endproperty
  a_desc_pulse: assert property (p_desc_pulse) else $error("req held");
  property p_desc_chain;
    desc_req_out |-> chain_en_in && busy_out;
  endproperty
  a_desc_chain: assert property (p_desc_chain) else $error("stray fetch");
  property p_no_backpressure;
    smp_ready_out;
  endproperty
  a_no_backpressure: assert property (p_no_backpressure) else $error("held");
  // short runs still leave the buffer; needs a host ready most cycles
  property p_flush;
    $fell(busy_out) |-> ##[0:24] !wr_valid_out;
  endproperty
  a_flush: assert property (p_flush) else $error("beats held");
  property p_trig_cause;
    $rose(trig_seen_out) |-> $past(trigger_in) && busy_out;
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("no trigger");
  c_done: cover property (done_out);
endmodule : sts_seq_chk

bind sts_seq sts_seq_chk i_chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .start_in(start_in), .chain_en_in(chain_en_in), .trigger_in(trigger_in),
  .desc_req_out(desc_req_out), .wr_valid_out(wr_valid_out),
  .wr_beat_out(wr_beat_out), .wr_ready_in(wr_ready_in),
  .busy_out(busy_out), .done_out(done_out), .trig_seen_out(trig_seen_out),
  .smp_ready_out(smp_ready_out));

//--- tb/sts_host_mdl.sv
// Purpose: host memory and descriptor list behind the sequencer
// Assumes: one descriptor answer per request, one cycle later
// Notes: ready drops one cycle in eight so the buffer fills on drains
`timescale 1ns/10ps
module sts_host_mdl
#(
  parameter logic [31:0] BASE = 32'h00001000
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clr_in,
  input wire logic stall_in,
  input wire logic wr_valid_in,
  input wire sts_pkg::sts_beat_type wr_beat_in,
  input wire logic desc_req_in,
  input wire logic [31:0] desc_ptr_in,
  output logic wr_ready_out,
  output logic desc_valid_out,
  output sts_pkg::sts_desc_type desc_out,
  output logic [31:0] beat_count_out,
  output sts_pkg::sts_beat_type first_beat_out
);
  logic [2:0] cyc_q;
  // list of three nodes, last points back to first
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cyc_q <= 3'h0;
      wr_ready_out <= 1'b0;
      desc_valid_out <= 1'b0;
      desc_out <= '0;
      beat_count_out <= 32'h00000000;
      first_beat_out <= '0;
    end
    else
    begin
      cyc_q <= cyc_q + 3'h1;
      wr_ready_out <= !(stall_in && cyc_q == 3'h0); // short stalls
      desc_valid_out <= desc_req_in;
      if (desc_req_in)
        desc_out <= {{desc_ptr_in[15:0], 16'h0000}, desc_ptr_in, 22'h000003,
          (desc_ptr_in == BASE + 32'h20) ? BASE : desc_ptr_in + 32'h10,
          1'b0};
      else if (desc_valid_out)
        desc_out <= ~desc_out; // released, never the old value
      if (clr_in)
        beat_count_out <= 32'h00000000;
      else if (wr_valid_in && wr_ready_out)
      begin
        if (beat_count_out == 32'h00000000)
          first_beat_out <= wr_beat_in;
        beat_count_out <= beat_count_out + 32'h1;
      end
    end
  end
endmodule : sts_host_mdl

//--- tb/testbench.sv
// Purpose: scenario bench for the scan trigger sequencer
// Assumes: two samples per scan, one sample every fourth cycle
// Notes: sample stream never stops, so alignment is really exercised
`timescale 1ns/10ps
module testbench;
  logic clock_in, nrst_in, start, chain_en, trig, clr;
  logic tick = 1'b0;
  logic smp_valid = 1'b0;
  logic stall, desc_req, desc_valid, wr_valid, wr_ready;
  logic busy, done, trig_seen, smp_ready;
  logic [31:0] desc_ptr, first_desc, beats;
  logic [1:0] ph_q = 2'h0;
  logic [3:0] ch_q = 4'h0;
  logic [11:0] scan_q = 12'h000;
  sts_pkg::sts_cfg_type cfg;
  sts_pkg::sts_smp_type smp = '0;
  sts_pkg::sts_desc_type desc;
  sts_pkg::sts_beat_type beat, first_beat;
  int err_count = 0;
  int compares = 0;
  sts_seq i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(start),
    .cfg_in(cfg), .chain_en_in(chain_en), .trigger_in(trig),
    .timebase_tick_in(tick), .smp_valid_in(smp_valid), .smp_in(smp),
    .desc_in(desc), .desc_valid_in(desc_valid), .desc_req_out(desc_req),
    .desc_ptr_out(desc_ptr), .first_desc_in(first_desc),
    .wr_valid_out(wr_valid), .wr_beat_out(beat), .wr_ready_in(wr_ready),
    .busy_out(busy), .done_out(done), .trig_seen_out(trig_seen),
    .smp_ready_out(smp_ready));
  sts_host_mdl i_host (.clock_in(clock_in), .nrst_in(nrst_in), .clr_in(clr),
    .stall_in(stall), .wr_valid_in(wr_valid), .wr_beat_in(beat),
    .desc_req_in(desc_req), .desc_ptr_in(desc_ptr),
    .wr_ready_out(wr_ready), .desc_valid_out(desc_valid), .desc_out(desc),
    .beat_count_out(beats), .first_beat_out(first_beat));
  // 250 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // endless scans of two channels, spaced so a descriptor reload never
  // meets a sample; timebase tick every other cycle
  always @(posedge clock_in)
  begin
    tick <= ~tick;
    ph_q <= ph_q + 2'h1;
    smp_valid <= (ph_q == 2'h0);
    if (ph_q == 2'h0)
    begin
      smp.first <= (ch_q == 4'h0);
      smp.data <= {scan_q, ch_q};
      ch_q <= (ch_q == 4'h1) ? 4'h0 : 4'h1;
      if (ch_q == 4'h1)
        scan_q <= scan_q + 12'h1;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic pulse_trig();
    trig <= 1'b1;
    @(posedge clock_in);
    trig <= 1'b0;
  endtask : pulse_trig
  // one acquisition: g0 always ends in a trigger, a g1 or g2 of zero skips that trigger; returns beat count
  task automatic run(input sts_pkg::sts_mode_type mode, input logic guard,
    input logic retrig, input logic chain, input logic [15:0] m,
    input logic [23:0] psc, input logic [15:0] lim, input int g0,
    input int g1, input int g2, output logic [31:0] got);
    int n;
    cfg.mode <= mode;
    cfg.guard_en <= guard;
    cfg.retrig_en <= retrig;
    cfg.pre_scan_count <= m;
    cfg.post_scan_count <= psc;
    cfg.retrig_limit <= lim;
    chain_en <= chain;
    clr <= 1'b1;
    @(posedge clock_in);
    clr <= 1'b0;
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    repeat (g0) @(posedge clock_in);
    pulse_trig();
    // look once the registered flag has settled
    @(negedge clock_in);
    check({31'h0, trig_seen}, {31'h0, !guard});
    if (g1 > 0)
    begin
      repeat (g1) @(posedge clock_in);
      pulse_trig();
    end
    if (g2 > 0)
    begin
      repeat (g2) @(posedge clock_in);
      pulse_trig();
    end
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clock_in);
      n++;
    end
    check({31'h0, done}, 32'h1);
    repeat (30) @(posedge clock_in);
    got = beats;
    check({28'h0, first_beat.data[3:0]}, 32'h0);
    check(first_beat.addr, chain ? {first_desc[15:0], 16'h0000}
      : first_desc);
  endtask : run
  // watchdog, well beyond the several hundred cycles the runs need
  initial
  begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    conclude();
  end
  initial
  begin
    logic [31:0] got;
    nrst_in = 1'b0;
    {start, chain_en, trig, clr} = '0;
    cfg = '0;
    cfg.samples_per_scan = 9'h002;
    cfg.sample_interval_count = 16'h0002;
    cfg.delay_count = 16'h0003;
    stall = 1'b1;
    first_desc = 32'h00001000;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    run(sts_pkg::MODE_POST, 0, 0, 0, 16'h0, 24'h2, 16'h1, 3, 0, 0, got);
    check(got, 32'h4);
    run(sts_pkg::MODE_MID, 1, 0, 0, 16'h2, 24'h1, 16'h1, 1, 30, 0, got);
    check(got, 32'h6);
    run(sts_pkg::MODE_PRE, 0, 0, 0, 16'h3, 24'h0, 16'h1, 30, 0, 0, got);
    check(got, 32'h6);
    run(sts_pkg::MODE_PRE, 0, 0, 0, 16'h3, 24'h0, 16'h1, 1, 0, 0, got);
    check({31'h0, got[0]}, 32'h0);
    check({31'h0, got < 32'h6}, 32'h1);
    run(sts_pkg::MODE_DELAY, 0, 0, 0, 16'h0, 24'h3, 16'h1, 5, 0, 0, got);
    check(got, 32'h6);
    // same delay counted on the divided sample clock
    cfg.dly_on_sample <= 1'b1;
    run(sts_pkg::MODE_DELAY, 0, 0, 0, 16'h0, 24'h3, 16'h1, 5, 0, 0, got);
    check(got, 32'h6);
    run(sts_pkg::MODE_POST, 0, 1, 0, 16'h0, 24'h2, 16'h2, 3, 2, 60, got);
    check(got, 32'h8);
    run(sts_pkg::MODE_POST, 0, 0, 1, 16'h0, 24'h5, 16'h1, 3, 0, 0, got);
    check(got, 32'ha);
    conclude();
  end
endmodule : testbench
